// ===== bsl_pkg.sv
// Shared types and constants for the branch, skip, load and store executor
package bsl_pkg;

  // Status flag bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Data-space addresses at or above this go through the NVM controller
  localparam logic [15:0] NVM_BASE = 16'h8000;

  // Program counter steps
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] PC_SKIP_LONG = 16'h0003;

  // Cycle counts per instruction outcome
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
  localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
  localparam logic [1:0] CYC_SKIP_LONG = 2'h3;
  localparam logic [1:0] CYC_LD_DIR = 2'h3;
  localparam logic [1:0] CYC_LD_IND = 2'h2;
  localparam logic [1:0] CYC_ST_DIR = 2'h2;
  localparam logic [1:0] CYC_ST_IND = 2'h1;

  typedef enum logic [4:0] {
    OP_NONE, OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TRANSFER_BIT_SET,
    OP_BRANCH_TRANSFER_BIT_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED, OP_LOAD_DIRECT, OP_LOAD_INDIRECT,
    OP_STORE_DIRECT, OP_STORE_INDIRECT
  } bsl_op_t;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z, PTR_RSVD} bsl_ptr_t;
  typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISP} bsl_amode_t;
  typedef enum logic [2:0] {S_IDLE = 3'h1, S_COUNT = 3'h2, S_NVM = 3'h4} bsl_state_t;

  typedef struct packed {
    bsl_op_t op;
    logic [4:0] reg_a;
    logic [4:0] reg_b;
    logic [2:0] bit_sel;
    bsl_ptr_t ptr_sel;
    bsl_amode_t mode;
    logic [5:0] disp;
    logic [6:0] offset;
    logic [15:0] addr;
  } bsl_cmd_t;

  typedef struct packed {
    logic load;
    logic flush;
    logic [15:0] target;
  } bsl_pc_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bsl_mem_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } bsl_rf_t;

  typedef struct packed {
    logic we;
    bsl_ptr_t sel;
    logic [15:0] data;
  } bsl_ptr_wr_t;

endpackage : bsl_pkg

// ===== bsl_exec.sv
// Executor for skip, conditional branch and data-space load/store instructions
`timescale 1ns/10ps
module bsl_exec
  import bsl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire bsl_cmd_t cmd,
  input wire logic [15:0] pc_in,
  input wire logic next_is_long,
  input wire logic [7:0] rf_a_val,
  input wire logic [7:0] rf_b_val,
  input wire logic io_bit,
  input wire logic [7:0] status_flags_reg,
  input wire logic [15:0] ptr_x,
  input wire logic [15:0] ptr_y,
  input wire logic [15:0] ptr_z,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready,
  output logic cmd_ready,
  output bsl_pc_t pc_out,
  output bsl_mem_t mem_out,
  output bsl_rf_t rf_out,
  output bsl_ptr_wr_t ptr_out
);

  function automatic logic [15:0] bsl_sext7(input logic [6:0] k);
    return {{9{k[6]}}, k};
  endfunction : bsl_sext7

  function automatic logic bsl_taken(input bsl_op_t op, input logic [7:0] fl,
                                     input logic [7:0] a, input logic [7:0] b,
                                     input logic [2:0] bs, input logic io);
    case (op)
      OP_COMPARE_SKIP_EQUAL: return a == b;
      OP_SKIP_REG_BIT_CLEAR: return !a[bs];
      OP_SKIP_REG_BIT_SET: return a[bs];
      OP_SKIP_IO_BIT_CLEAR: return !io;
      OP_SKIP_IO_BIT_SET: return io;
      OP_BRANCH_FLAG_SET: return fl[bs];
      OP_BRANCH_FLAG_CLEAR: return !fl[bs];
      OP_BRANCH_UNSIGNED_GE: return !fl[FLAG_C];
      OP_BRANCH_UNSIGNED_LT: return fl[FLAG_C];
      OP_BRANCH_SIGNED_GE: return !(fl[FLAG_N] ^ fl[FLAG_V]);
      OP_BRANCH_SIGNED_LT: return fl[FLAG_N] ^ fl[FLAG_V];
      OP_BRANCH_HALFCARRY_SET: return fl[FLAG_H];
      OP_BRANCH_HALFCARRY_CLEAR: return !fl[FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET: return fl[FLAG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR: return !fl[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: return fl[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: return !fl[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: return fl[FLAG_I];
      OP_BRANCH_IRQ_DISABLED: return !fl[FLAG_I];
      default: return 1'b0;
    endcase
  endfunction : bsl_taken

  bsl_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic nvm_seen_reg, nvm_seen_next;
  logic ready_reg, ready_next;
  logic ld_reg, ld_next;
  logic [4:0] ld_dst_reg, ld_dst_next;
  bsl_pc_t pc_reg, pc_next;
  bsl_mem_t mem_reg, mem_next;
  bsl_rf_t rf_reg, rf_next;
  bsl_ptr_wr_t ptr_reg, ptr_next;

  // Decode of the offered command
  logic acc_c, taken_c, is_skip_c, is_branch_c, is_load_c, is_store_c, is_mem_c;
  logic [15:0] pv_c, ea_c;
  logic [1:0] base_c;

  // A flush cycle never takes a command: the discarded word must not execute
  assign acc_c = cmd_valid && (state_reg == S_IDLE) && !pc_reg.flush;

  always_comb begin
    is_skip_c = cmd.op inside {OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
    is_branch_c = (cmd.op >= OP_BRANCH_FLAG_SET) && (cmd.op <= OP_BRANCH_IRQ_DISABLED);
    is_load_c = (cmd.op == OP_LOAD_DIRECT) ||
      ((cmd.op == OP_LOAD_INDIRECT) && (cmd.ptr_sel != PTR_RSVD));
    is_store_c = (cmd.op == OP_STORE_DIRECT) ||
      ((cmd.op == OP_STORE_INDIRECT) && (cmd.ptr_sel != PTR_RSVD));
    is_mem_c = is_load_c || is_store_c;
    taken_c = bsl_taken(cmd.op, status_flags_reg, rf_a_val, rf_b_val, cmd.bit_sel, io_bit);
    unique case (cmd.ptr_sel)
      PTR_X: pv_c = ptr_x;
      PTR_Y: pv_c = ptr_y;
      PTR_Z: pv_c = ptr_z;
      PTR_RSVD: pv_c = 16'h0000;
    endcase
    ea_c = pv_c;
    if (cmd.op == OP_LOAD_DIRECT || cmd.op == OP_STORE_DIRECT) begin
      ea_c = cmd.addr;
    end else if (cmd.mode == AM_PREDEC) begin
      ea_c = pv_c - PC_STEP;
    end else if (cmd.mode == AM_DISP && cmd.ptr_sel != PTR_X) begin
      // X has no displaced form; a displaced X request acts as plain
      ea_c = pv_c + {10'h000, cmd.disp};
    end
    unique case (cmd.op)
      OP_LOAD_DIRECT: base_c = CYC_LD_DIR;
      OP_LOAD_INDIRECT: base_c = CYC_LD_IND;
      OP_STORE_DIRECT: base_c = CYC_ST_DIR;
      default: base_c = CYC_ST_IND;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    nvm_seen_next = nvm_seen_reg;
    ld_next = ld_reg;
    ld_dst_next = ld_dst_reg;
    pc_next = '{load: 1'b0, flush: 1'b0, target: pc_reg.target};
    mem_next = '{req: 1'b0, we: mem_reg.we, addr: mem_reg.addr, wdata: mem_reg.wdata};
    ptr_next = '{we: 1'b0, sel: ptr_reg.sel, data: ptr_reg.data};
    // Load data is taken in the cycle the access completes
    rf_next.we = mem_reg.req && ld_reg && mem_ready && ((state_reg != S_NVM) || nvm_seen_reg);
    rf_next.addr = ld_dst_reg;
    rf_next.data = rf_next.we ? mem_rdata : rf_reg.data;
    unique case (state_reg)
      S_IDLE: begin
        if (acc_c && is_skip_c && taken_c) begin
          pc_next.load = 1'b1;
          pc_next.flush = 1'b1;
          pc_next.target = pc_in + (next_is_long ? PC_SKIP_LONG : PC_SKIP_SHORT);
          cnt_next = (next_is_long ? CYC_SKIP_LONG : CYC_SKIP_SHORT) - CYC_ONE;
          state_next = S_COUNT;
        end else if (acc_c && is_branch_c && taken_c) begin
          pc_next.load = 1'b1;
          pc_next.flush = 1'b1;
          pc_next.target = pc_in + bsl_sext7(cmd.offset) + PC_STEP;
          cnt_next = CYC_BR_TAKEN - CYC_ONE;
          state_next = S_COUNT;
        end else if (acc_c && is_mem_c) begin
          mem_next = '{req: 1'b1, we: is_store_c, addr: ea_c, wdata: rf_a_val};
          ld_next = is_load_c;
          ld_dst_next = cmd.reg_a;
          if (cmd.op inside {OP_LOAD_INDIRECT, OP_STORE_INDIRECT}) begin
            if (cmd.mode == AM_POSTINC) begin
              ptr_next = '{we: 1'b1, sel: cmd.ptr_sel, data: pv_c + PC_STEP};
            end else if (cmd.mode == AM_PREDEC) begin
              ptr_next = '{we: 1'b1, sel: cmd.ptr_sel, data: ea_c};
            end
          end
          cnt_next = base_c - CYC_ONE;
          nvm_seen_next = 1'b0;
          if (ea_c >= NVM_BASE) begin
            state_next = S_NVM;
          end else if (base_c > CYC_ONE) begin
            state_next = S_COUNT;
          end
        end
      end
      S_COUNT: begin
        cnt_next = cnt_reg - CYC_ONE;
        if (cnt_reg <= CYC_ONE) begin
          state_next = S_IDLE;
        end
      end
      S_NVM: begin
        // First NVM cycle never completes, so at least one cycle is added
        nvm_seen_next = 1'b1;
        if (mem_ready && nvm_seen_reg) begin
          if (cnt_reg > CYC_ONE) begin
            cnt_next = cnt_reg - CYC_ONE;
            state_next = S_COUNT;
          end else begin
            state_next = S_IDLE;
          end
        end else begin
          mem_next.req = 1'b1;
        end
      end
    endcase
    ready_next = (state_next == S_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 2'h0;
      nvm_seen_reg <= 1'b0;
      ready_reg <= 1'b1;
      ld_reg <= 1'b0;
      ld_dst_reg <= 5'h00;
      pc_reg <= '0;
      mem_reg <= '0;
      rf_reg <= '0;
      ptr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      nvm_seen_reg <= nvm_seen_next;
      ready_reg <= ready_next;
      ld_reg <= ld_next;
      ld_dst_reg <= ld_dst_next;
      pc_reg <= pc_next;
      mem_reg <= mem_next;
      rf_reg <= rf_next;
      ptr_reg <= ptr_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign pc_out = pc_reg;
  assign mem_out = mem_reg;
  assign rf_out = rf_reg;
  assign ptr_out = ptr_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_equal_skip_target: assert property (
    acc_c && cmd.op == OP_COMPARE_SKIP_EQUAL && rf_a_val == rf_b_val |=> pc_reg.load &&
    pc_reg.target == $past(pc_in) + ($past(next_is_long) ? PC_SKIP_LONG : PC_SKIP_SHORT))
    else $error("equal compare did not skip to the right address");

  chk_regbit_no_skip: assert property (
    acc_c && ((cmd.op == OP_SKIP_REG_BIT_CLEAR && rf_a_val[cmd.bit_sel]) ||
    (cmd.op == OP_SKIP_REG_BIT_SET && !rf_a_val[cmd.bit_sel])) |=> !pc_reg.load && ready_reg)
    else $error("register bit skip taken on wrong bit value");

  chk_iobit_skip_len: assert property (
    acc_c && ((cmd.op == OP_SKIP_IO_BIT_CLEAR && !io_bit) ||
    (cmd.op == OP_SKIP_IO_BIT_SET && io_bit)) && next_is_long |=>
    pc_reg.load && !ready_reg ##1 !ready_reg ##1 ready_reg)
    else $error("I/O bit skip over long word not three cycles");

  chk_flag_branch_target: assert property (
    acc_c && cmd.op == OP_BRANCH_FLAG_SET && status_flags_reg[cmd.bit_sel] |=>
    pc_reg.target == $past(pc_in) + bsl_sext7($past(cmd.offset)) + 16'h0001)
    else $error("flag branch target is not PC plus offset plus one");

  chk_unsigned_not_taken: assert property (
    acc_c && cmd.op == OP_BRANCH_UNSIGNED_LT && !status_flags_reg[FLAG_C] |=>
    !pc_reg.load && ready_reg)
    else $error("unsigned lower branch taken with carry clear");

  chk_signed_ge_fall: assert property (
    acc_c && cmd.op == OP_BRANCH_SIGNED_GE &&
    (status_flags_reg[FLAG_N] ^ status_flags_reg[FLAG_V]) |=> !pc_reg.load)
    else $error("signed ge branch taken with N xor V set");

  chk_signed_lt_taken: assert property (
    acc_c && cmd.op == OP_BRANCH_SIGNED_LT &&
    (status_flags_reg[FLAG_N] ^ status_flags_reg[FLAG_V]) |=>
    pc_reg.load && pc_reg.flush && !ready_reg ##1 ready_reg)
    else $error("signed lt branch not taken in two cycles");

  chk_misc_flag_branch: assert property (
    acc_c && ((cmd.op == OP_BRANCH_IRQ_DISABLED && !status_flags_reg[FLAG_I]) ||
    (cmd.op == OP_BRANCH_TRANSFER_BIT_SET && status_flags_reg[FLAG_T]) ||
    (cmd.op == OP_BRANCH_OVERFLOW_CLEAR && !status_flags_reg[FLAG_V])) |=> pc_reg.load)
    else $error("flag branch not taken when its condition held");

  chk_load_direct_time: assert property (
    acc_c && cmd.op == OP_LOAD_DIRECT && cmd.addr < NVM_BASE |=>
    mem_reg.req && !mem_reg.we && mem_reg.addr == $past(cmd.addr) && !ready_reg
    ##1 !ready_reg ##1 ready_reg)
    else $error("internal direct load not three cycles");

  chk_post_increment: assert property (
    acc_c && cmd.op inside {OP_LOAD_INDIRECT, OP_STORE_INDIRECT} && cmd.mode == AM_POSTINC &&
    cmd.ptr_sel != PTR_RSVD |=> ptr_reg.we && ptr_reg.data == mem_reg.addr + 16'h0001)
    else $error("post-increment pointer write wrong");

  chk_pre_decrement: assert property (
    acc_c && cmd.op inside {OP_LOAD_INDIRECT, OP_STORE_INDIRECT} && cmd.mode == AM_PREDEC &&
    cmd.ptr_sel == PTR_X |=> ptr_reg.we && mem_reg.addr == $past(ptr_x) - 16'h0001 &&
    ptr_reg.data == mem_reg.addr)
    else $error("pre-decrement address or pointer wrong");

  chk_displaced_addr: assert property (
    acc_c && cmd.op inside {OP_LOAD_INDIRECT, OP_STORE_INDIRECT} && cmd.mode == AM_DISP &&
    cmd.ptr_sel == PTR_Y |=> !ptr_reg.we && mem_reg.addr == $past(ptr_y) + {10'h000,
    $past(cmd.disp)})
    else $error("displaced access address wrong or pointer changed");

  chk_store_direct_time: assert property (
    acc_c && cmd.op == OP_STORE_DIRECT && cmd.addr < NVM_BASE |=>
    mem_reg.req && mem_reg.we && !ready_reg ##1 ready_reg && !mem_reg.req)
    else $error("internal direct store not two cycles");

  chk_nvm_extra_cycle: assert property (
    state_reg == S_NVM && !nvm_seen_reg |-> mem_reg.req && !ready_reg ##1
    !rf_reg.we && !ready_reg)
    else $error("NVM access completed without an extra cycle");

  chk_flush_blocks: assert property (
    pc_reg.flush |-> !ready_reg && !acc_c)
    else $error("command accepted while the fetched word is discarded");

endmodule : bsl_exec

// ===== bsl_mem_model.sv
// Data-space memory model standing on the far side of the executor
`timescale 1ns/10ps
module bsl_mem_model
  import bsl_pkg::*;
#(
  parameter int NVM_WAIT = 2
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire bsl_mem_t mem_out,
  output logic [7:0] mem_rdata,
  output logic mem_ready
);
  logic [7:0] mem [256];
  logic [7:0] last;
  logic is_nvm;
  int wait_cnt;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end

  assign is_nvm = (mem_out.addr >= NVM_BASE);
  // Internal RAM answers at once; the NVM path never completes in its first cycle
  assign mem_ready = mem_out.req && (!is_nvm || wait_cnt >= NVM_WAIT);
  // Idle bus toggles every cycle, so a read taken at the wrong cycle cannot match
  assign mem_rdata = (mem_ready && !mem_out.we) ? mem[mem_out.addr[7:0]] : ~last;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 0;
      last <= 8'h00;
    end else begin
      last <= mem_rdata;
      if (mem_ready) begin
        wait_cnt <= 0;
      end else if (mem_out.req && is_nvm) begin
        wait_cnt <= wait_cnt + 1;
      end
      if (mem_ready && mem_out.we) begin
        mem[mem_out.addr[7:0]] <= mem_out.wdata;
      end
    end
  end
endmodule : bsl_mem_model

// ===== testbench.sv
// Self-checking testbench for the branch, skip, load and store executor
`timescale 1ns/10ps
module testbench;
  import bsl_pkg::*;
  localparam int NVM_WAIT = 2;
  typedef struct packed {
    bsl_op_t op;
    bsl_ptr_t p;
    bsl_amode_t m;
    logic [5:0] q;
    logic [15:0] ad;
    logic rq;
    logic pw;
    logic [15:0] pd;
    logic [2:0] n;
  } bsl_case_t;
  logic clk, resetn, cmd_valid, next_is_long, io_bit, mem_ready, cmd_ready;
  logic [15:0] pc_in, ptr_x, ptr_y, ptr_z, tgt, maddr, pdat;
  logic [7:0] rf_a_val, rf_b_val, status_flags_reg, mem_rdata, rfd, mwd, av, fl;
  logic ld_seen, fl_seen, rfw, pw, mreq, mwe, tk, st;
  logic [4:0] rfa;
  bsl_cmd_t cmd, c;
  bsl_pc_t pc_out;
  bsl_mem_t mem_out;
  bsl_rf_t rf_out;
  bsl_ptr_wr_t ptr_out;
  bsl_ptr_t psel;
  bsl_op_t op;
  bsl_case_t t;
  int n_fail, tests_run, n_cyc;
  bsl_case_t tbl [12] = '{
    '{OP_LOAD_DIRECT, PTR_X, AM_PLAIN, 6'h00, 16'h0123, 1'b1, 1'b0, 16'h0000, 3'h3},
    '{OP_LOAD_INDIRECT, PTR_X, AM_PLAIN, 6'h00, 16'h0100, 1'b1, 1'b0, 16'h0000, 3'h2},
    '{OP_LOAD_INDIRECT, PTR_X, AM_POSTINC, 6'h00, 16'h0100, 1'b1, 1'b1, 16'h0101, 3'h2},
    '{OP_LOAD_INDIRECT, PTR_Y, AM_PREDEC, 6'h00, 16'h01FF, 1'b1, 1'b1, 16'h01FF, 3'h2},
    '{OP_LOAD_INDIRECT, PTR_Z, AM_DISP, 6'h3F, 16'h043E, 1'b1, 1'b0, 16'h0000, 3'h2},
    '{OP_LOAD_INDIRECT, PTR_X, AM_DISP, 6'h3F, 16'h0100, 1'b1, 1'b0, 16'h0000, 3'h2},
    '{OP_LOAD_INDIRECT, PTR_RSVD, AM_POSTINC, 6'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 3'h1},
    '{OP_STORE_DIRECT, PTR_X, AM_PLAIN, 6'h00, 16'h0345, 1'b1, 1'b0, 16'h0000, 3'h2},
    '{OP_STORE_INDIRECT, PTR_Z, AM_POSTINC, 6'h00, 16'h03FF, 1'b1, 1'b1, 16'h0400, 3'h1},
    '{OP_STORE_INDIRECT, PTR_X, AM_PREDEC, 6'h00, 16'h00FF, 1'b1, 1'b1, 16'h00FF, 3'h1},
    '{OP_STORE_INDIRECT, PTR_Y, AM_DISP, 6'h01, 16'h0201, 1'b1, 1'b0, 16'h0000, 3'h1},
    '{OP_STORE_DIRECT, PTR_X, AM_PLAIN, 6'h00, 16'h8001, 1'b1, 1'b0, 16'h0000, 3'(NVM_WAIT + 2)}
  };

  bsl_exec u_bsl_exec (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .pc_in(pc_in), .next_is_long(next_is_long), .rf_a_val(rf_a_val), .rf_b_val(rf_b_val),
    .io_bit(io_bit), .status_flags_reg(status_flags_reg), .ptr_x(ptr_x), .ptr_y(ptr_y),
    .ptr_z(ptr_z), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .cmd_ready(cmd_ready),
    .pc_out(pc_out), .mem_out(mem_out), .rf_out(rf_out), .ptr_out(ptr_out));
  bsl_mem_model #(.NVM_WAIT(NVM_WAIT)) u_bsl_mem_model (.clk(clk), .resetn(resetn),
    .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ready(mem_ready));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("Counts: %0d compared, %0d wrong", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Offers one command, then records every output pulse until ready returns
  task automatic exec(input bsl_cmd_t cc, input logic [15:0] pc, input logic lng,
                      input logic [7:0] a, input logic [7:0] b, input logic io,
                      input logic [7:0] f);
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
    cmd <= cc;
    pc_in <= pc;
    next_is_long <= lng;
    rf_a_val <= a;
    rf_b_val <= b;
    io_bit <= io;
    status_flags_reg <= f;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    {ld_seen, fl_seen, rfw, pw, mreq, mwe} = '0;
    n_cyc = 0;
    for (i = 1; i <= 12 && n_cyc == 0; i++) begin
      @(negedge clk);
      if (pc_out.load === 1'b1) {ld_seen, tgt} = {1'b1, pc_out.target};
      if (pc_out.flush === 1'b1) fl_seen = 1'b1;
      if (rf_out.we === 1'b1) {rfw, rfa, rfd} = {1'b1, rf_out.addr, rf_out.data};
      if (ptr_out.we === 1'b1) {pw, psel, pdat} = {1'b1, ptr_out.sel, ptr_out.data};
      if (mem_out.req === 1'b1) {mreq, mwe, maddr, mwd} = {1'b1, mem_out.we, mem_out.addr,
                                                           mem_out.wdata};
      if (cmd_ready === 1'b1) n_cyc = i;
    end
  endtask : exec

  function automatic logic br_exp(input bsl_op_t o, input logic [7:0] f, input logic [2:0] bs);
    case (o)
      OP_BRANCH_FLAG_SET: return f[bs];
      OP_BRANCH_FLAG_CLEAR: return !f[bs];
      OP_BRANCH_UNSIGNED_GE: return !f[FLAG_C];
      OP_BRANCH_UNSIGNED_LT: return f[FLAG_C];
      OP_BRANCH_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_SIGNED_LT: return f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_HALFCARRY_SET: return f[FLAG_H];
      OP_BRANCH_HALFCARRY_CLEAR: return !f[FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET: return f[FLAG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR: return !f[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: return f[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: return !f[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: return f[FLAG_I];
      default: return !f[FLAG_I];
    endcase
  endfunction : br_exp

  initial begin
    {resetn, cmd_valid, next_is_long, io_bit} = '0;
    {cmd, pc_in, rf_a_val, rf_b_val, status_flags_reg} = '0;
    ptr_x = 16'h0100;
    ptr_y = 16'h0200;
    ptr_z = 16'h03FF;
    n_fail = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int o = OP_BRANCH_FLAG_SET; o <= OP_BRANCH_IRQ_DISABLED; o++) begin
      for (int j = 0; j < 10; j++) begin
        fl = (j < 8) ? (8'h01 << j) : ((j == 8) ? 8'h00 : 8'hFF);
        c = '0;
        c.op = bsl_op_t'(o);
        c.bit_sel = 3'(j + 3);
        c.offset = j[0] ? 7'h40 : 7'h3F;
        tk = br_exp(c.op, fl, c.bit_sel);
        exec(c, 16'h0010, 1'b0, 8'h11, 8'h22, 1'b0, fl);
        check(ld_seen, tk, "branch taken");
        check(n_cyc, tk ? 2 : 1, "branch cycles");
        check(fl_seen, tk, "branch flush");
        check({rfw, pw, mreq}, 3'h0, "branch side effect");
        if (tk) check(tgt, 16'h0011 + {{9{c.offset[6]}}, c.offset}, "target");
      end
    end
    $display("Branch test done");
    for (int o = OP_COMPARE_SKIP_EQUAL; o <= OP_SKIP_IO_BIT_SET; o++) begin
      for (int j = 0; j < 4; j++) begin
        c = '0;
        c.op = bsl_op_t'(o);
        c.bit_sel = 3'h2;
        av = j[1] ? 8'hA5 : 8'h5A;
        case (c.op)
          OP_COMPARE_SKIP_EQUAL: tk = j[1];
          OP_SKIP_REG_BIT_CLEAR: tk = !av[2];
          OP_SKIP_IO_BIT_CLEAR: tk = !j[1];
          default: tk = j[1];
        endcase
        exec(c, 16'h0200, j[0], av, (c.op == OP_COMPARE_SKIP_EQUAL && !j[1]) ? ~av : av, j[1],
             8'h00);
        check(ld_seen, tk, "skip taken");
        check(n_cyc, tk ? (j[0] ? 3 : 2) : 1, "skip cycles");
        check({rfw, pw, mreq}, 3'h0, "skip side effect");
        if (tk) check(tgt, j[0] ? 16'h0203 : 16'h0202, "skip target");
      end
    end
    $display("Skip test done");
    foreach (tbl[k]) begin
      t = tbl[k];
      st = (t.op == OP_STORE_DIRECT || t.op == OP_STORE_INDIRECT);
      c = '0;
      c.op = t.op;
      c.reg_a = 5'(k + 3);
      c.ptr_sel = t.p;
      c.mode = t.m;
      c.disp = t.q;
      c.addr = t.ad;
      exec(c, 16'h0040, 1'b0, 8'h3C + 8'(k), 8'h00, 1'b0, 8'h00);
      check(n_cyc, t.n, "access cycles");
      check(mreq, t.rq, "request");
      check(pw, t.pw, "pointer write");
      check(rfw, t.rq && !st, "register write");
      check(ld_seen, 1'b0, "no jump");
      if (mreq) check({mwe, maddr}, {st, t.ad}, "address");
      if (pw) check({psel, pdat}, {t.p, t.pd}, "pointer value");
      if (rfw) check({rfa, rfd}, {c.reg_a, t.ad[7:0] ^ 8'hA5}, "load data");
      if (st) check(mwd, 8'h3C + 8'(k), "store data");
    end
    $display("Load and store test done");
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end
endmodule : testbench
